// File: gcc_pkg.sv
package gcc_pkg;

	// ************************************************************
	// Curve geometry
	// ************************************************************
	localparam int NUM_BP = 19;                        // Breakpoints on the curve
	localparam int IN_W   = 12;                        // Pixel component width in
	localparam int OUT_W  = 8;                         // Pixel component width out
	localparam logic [11:0] BP_LAST  = 12'hfff;        // Top breakpoint input
	localparam logic [4:0]  IDX_LAST = 5'h12;          // Index of the top breakpoint

	// ************************************************************
	// Mode configuration group
	// ************************************************************
	localparam logic [7:0] CFG_OFS_MODE_A = 8'h43;     // Preset byte of the first mode
	localparam logic [7:0] CFG_OFS_MODE_B = 8'h44;     // Preset byte of the second mode
	localparam int GAM_LSB = 0;                        // Gamma choice field, 3 bits
	localparam int CON_LSB = 4;                        // Contrast choice field, 3 bits
	localparam logic [7:0] CFG_RST = 8'h00;            // Preset byte after reset

	// Gamma choices
	localparam logic [2:0] GAM_ID   = 3'h0;
	localparam logic [2:0] GAM_056  = 3'h1;
	localparam logic [2:0] GAM_045  = 3'h2;
	localparam logic [2:0] GAM_USER = 3'h3;

	// Contrast choices
	localparam logic [2:0] CON_NONE = 3'h0;
	localparam logic [2:0] CON_125  = 3'h1;
	localparam logic [2:0] CON_150  = 3'h2;
	localparam logic [2:0] CON_175  = 3'h3;
	localparam logic [2:0] CON_NR   = 3'h4;

	// ************************************************************
	// S-curve constants, slopes in eighths
	// ************************************************************
	localparam int SLOPE_125 = 10;
	localparam int SLOPE_150 = 12;
	localparam int SLOPE_175 = 14;
	localparam int SLOPE_NR  = 9;                      // Gentle curve, crushes shadows and highlights alike
	// Join point x1 = 255*(m-1)/m, end gain k = 32768*m/x1 (Q16)
	localparam int X1_125 = (255 * (SLOPE_125 - 8)) / SLOPE_125;
	localparam int X1_150 = (255 * (SLOPE_150 - 8)) / SLOPE_150;
	localparam int X1_175 = (255 * (SLOPE_175 - 8)) / SLOPE_175;
	localparam int X1_NR  = (255 * (SLOPE_NR - 8)) / SLOPE_NR;
	localparam int K_125  = (4096 * SLOPE_125) / X1_125;
	localparam int K_150  = (4096 * SLOPE_150) / X1_150;
	localparam int K_175  = (4096 * SLOPE_175) / X1_175;
	localparam int K_NR   = (4096 * SLOPE_NR) / X1_NR;

	// ************************************************************
	// Preset gamma tables, entry 0 in the low byte
	// ************************************************************
	typedef logic [NUM_BP*8-1:0] gcc_tbl_t;
	localparam gcc_tbl_t GAM_TBL_ID = {8'hff, 8'hef, 8'hdf, 8'hcf, 8'hbf, 8'haf, 8'h9f,
		8'h8f, 8'h80, 8'h70, 8'h60, 8'h50, 8'h40, 8'h30, 8'h20, 8'h10, 8'h08, 8'h04, 8'h00};
	localparam gcc_tbl_t GAM_TBL_056 = {8'hff, 8'hf6, 8'hed, 8'he3, 8'hd9, 8'hcf, 8'hc4,
		8'hb9, 8'had, 8'ha1, 8'h93, 8'h85, 8'h75, 8'h64, 8'h50, 8'h36, 8'h25, 8'h19, 8'h00};
	localparam gcc_tbl_t GAM_TBL_045 = {8'hff, 8'hf8, 8'hf0, 8'he8, 8'he0, 8'hd8, 8'hce,
		8'hc5, 8'hbb, 8'hb0, 8'ha4, 8'h97, 8'h89, 8'h78, 8'h64, 8'h49, 8'h36, 8'h27, 8'h00};

	// ************************************************************
	// Pixel carriers
	// ************************************************************
	typedef struct packed {
		logic            valid;                        // Component set present
		logic            sof;                          // First pixel of a frame
		logic [IN_W-1:0] r;
		logic [IN_W-1:0] g;
		logic [IN_W-1:0] b;
	} gcc_pix_in_t;

	typedef struct packed {
		logic             valid;
		logic             sof;
		logic [OUT_W-1:0] r;
		logic [OUT_W-1:0] g;
		logic [OUT_W-1:0] b;
	} gcc_pix_out_t;

	// Input position of breakpoint idx
	function automatic logic [11:0] bp_x(input logic [4:0] idx);
		logic [11:0] x;
		x = 12'h000;
		if (idx == 5'h01) begin
			x = 12'h040;
		end else if (idx == 5'h02) begin
			x = 12'h080;
		end else if (idx == IDX_LAST) begin
			x = BP_LAST;
		end else if (idx != 5'h00) begin
			x = {idx[3:0] - 4'h2, 8'h00};
		end
		return x;
	endfunction

	// Preset gamma output at breakpoint idx; unused codes fall back to identity
	function automatic logic [7:0] gam_entry(input logic [2:0] sel, input logic [4:0] idx);
		logic [7:0] v;
		case (sel)
			GAM_056: v = GAM_TBL_056[{idx, 3'b000} +: 8];
			GAM_045: v = GAM_TBL_045[{idx, 3'b000} +: 8];
			default: v = GAM_TBL_ID[{idx, 3'b000} +: 8];
		endcase
		return v;
	endfunction

endpackage

// File: gcc_scurve.sv
// Contrast S-curve applied to one 8-bit curve point, combinational
module gcc_scurve (
	input  wire logic [7:0] val_in,
	input  wire logic [2:0] con_in,
	output logic      [7:0] val_out
);

	// ************************************************************
	// Curve evaluation
	// ************************************************************
	// Per-setting slope, join point and end gain come from constants,
	// so no divider is built in hardware
	always_comb begin
		int s;
		int x1;
		int k;
		int xi;
		int v;
		s = 0;
		x1 = 0;
		k = 0;
		xi = int'(val_in);
		v = xi;
		case (con_in)
			gcc_pkg::CON_125: begin
				s = gcc_pkg::SLOPE_125; x1 = gcc_pkg::X1_125; k = gcc_pkg::K_125;
			end
			gcc_pkg::CON_150: begin
				s = gcc_pkg::SLOPE_150; x1 = gcc_pkg::X1_150; k = gcc_pkg::K_150;
			end
			gcc_pkg::CON_175: begin
				s = gcc_pkg::SLOPE_175; x1 = gcc_pkg::X1_175; k = gcc_pkg::K_175;
			end
			gcc_pkg::CON_NR: begin
				s = gcc_pkg::SLOPE_NR; x1 = gcc_pkg::X1_NR; k = gcc_pkg::K_NR;
			end
			default: s = 0;                            // No contrast, codes 5-7 too
		endcase
		if (s != 0) begin
			// Shadow: k*x^2, flat at black, meets the line at x1
			if (xi <= x1) begin
				v = (k * xi * xi) >>> 16;              // Zero at black
			// Highlight mirrors the shadow, reaches full scale at white
			end else if (xi >= 255 - x1) begin
				v = 255 - ((k * (255 - xi) * (255 - xi)) >>> 16);
			// Midtones: straight line of slope s/8 through mid-grey
			end else begin
				v = 128 + ((s * (xi - 128)) >>> 3);
			end
		end
		// Every piece stays inside the range, joins included; the clamp is only a guard
		if (v < 0) begin
			val_out = 8'h00;
		end else if (v > 255) begin
			val_out = 8'hff;
		end else begin
			val_out = 8'(v);
		end
	end

endmodule

// File: gcc_interp.sv
// Piecewise linear lookup of one colour component, one cycle latency
module gcc_interp (
	input  wire logic              clk_in,
	input  wire logic              rstn_in,
	input  wire logic [11:0]       x_in,
	input  wire gcc_pkg::gcc_tbl_t tbl_in,
	output logic      [7:0]        y_out
);

	logic [4:0] seg;                                   // Segment holding x_in
	logic [7:0] y_nxt;                                 // Interpolated value

	// ************************************************************
	// Segment search and interpolation
	// ************************************************************
	// Segment widths are powers of two except the top one (255 wide);
	// the top input is pinned to the last point instead of dividing
	always_comb begin
		int d;
		int p;
		int v;
		d = 0;
		p = 0;
		v = 0;
		if (x_in < 12'h040) begin
			seg = 5'h00;
		end else if (x_in < 12'h080) begin
			seg = 5'h01;
		end else if (x_in < 12'h100) begin
			seg = 5'h02;
		end else begin
			seg = {1'b0, x_in[11:8]} + 5'h02;
		end
		d = int'(tbl_in[{seg + 5'h01, 3'b000} +: 8]) - int'(tbl_in[{seg, 3'b000} +: 8]);
		p = d * int'(x_in - gcc_pkg::bp_x(seg));
		if (seg < 5'h02) begin
			p = p >>> 6;
		end else if (seg == 5'h02) begin
			p = p >>> 7;
		end else begin
			p = p >>> 8;
		end
		v = int'(tbl_in[{seg, 3'b000} +: 8]) + p;
		if (x_in == gcc_pkg::BP_LAST) begin
			v = int'(tbl_in[{gcc_pkg::IDX_LAST, 3'b000} +: 8]);
		end
		// Saturate to the output range
		if (v < 0) begin
			y_nxt = 8'h00;
		end else if (v > 255) begin
			y_nxt = 8'hff;
		end else begin
			y_nxt = 8'(v);
		end
	end

	// Output register
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			y_out <= 8'h00;
		end else begin
			y_out <= y_nxt;
		end
	end

endmodule

// File: gcc_tone_curve.sv
module gcc_tone_curve (
	input  wire logic                  clk_in,
	input  wire logic                  rstn_in,
	input  wire gcc_pkg::gcc_pix_in_t  px_in,
	output gcc_pkg::gcc_pix_out_t      px_out,
	input  wire logic                  mode_b_sel_in,
	input  wire logic [7:0]            mode_a_cfg_in,
	input  wire logic [7:0]            mode_b_cfg_in,
	input  wire logic                  user_wr_in,
	input  wire logic [4:0]            user_idx_in,
	input  wire logic [7:0]            user_data_in,
	input  wire logic                  rebuild_in,
	output logic                       busy_out,
	output logic                       curve_pending_out
);

	// ************************************************************
	// Declarations
	// ************************************************************
	typedef enum logic {ST_IDLE, ST_BUILD} gcc_state_t;

	gcc_state_t        state_r;                        // Curve builder state
	logic [4:0]        idx_r;                          // Breakpoint being built
	logic [7:0]        cfg_r;                          // Preset byte used by this build
	logic [7:0]        cur_cfg;                        // Preset byte of the active mode
	logic              req_r;                          // A rebuild is owed
	logic              start;                          // Build begins this cycle
	logic              swap_pend_r;                    // Built curve waits for a frame
	logic              swap_now;                       // Curve swap on this pixel
	logic [7:0]        user_tbl_r [gcc_pkg::NUM_BP];   // Uploaded gamma points
	gcc_pkg::gcc_tbl_t pend_tbl_r;                     // Curve under construction
	gcc_pkg::gcc_tbl_t act_tbl_r;                      // Curve applied to pixels
	gcc_pkg::gcc_tbl_t cur_tbl;                        // Curve seen by this pixel
	logic [7:0]        gam_pt;                         // Gamma point feeding contrast
	logic [7:0]        con_pt;                         // Point after contrast
	logic              valid_r;                        // Delayed valid
	logic              sof_r;                          // Delayed frame start
	logic [7:0]        y_r;                            // Red result
	logic [7:0]        y_g;                            // Green result
	logic [7:0]        y_b;                            // Blue result
	logic [7:0]        top_y;                          // Curve value at full scale
	logic [7:0]        bot_y;                          // Curve value at black

	// ************************************************************
	// Mode selection and rebuild request
	// ************************************************************
	// Each mode owns its preset byte; the selected mode drives builds
	assign cur_cfg = mode_b_sel_in ? mode_b_cfg_in : mode_a_cfg_in;
	assign start   = (state_r == ST_IDLE) && req_r;

	// A request raised in the start cycle survives: set wins over clear.
	// Changing the preset byte mid-build simply queues another build.
	// A byte change seen in the start cycle is taken by that build, so it
	// must not leave a second, needless request behind.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			req_r <= 1'b1;                             // Build once after reset
		end else if (rebuild_in || user_wr_in || ((cur_cfg != cfg_r) && !start)) begin
			req_r <= 1'b1;
		end else if (start) begin
			req_r <= 1'b0;
		end
	end

	// ************************************************************
	// User gamma table
	// ************************************************************
	// Out-of-range indices are dropped silently
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < gcc_pkg::NUM_BP; i++) begin
				user_tbl_r[i] <= gcc_pkg::GAM_TBL_ID[i*8 +: 8];
			end
		end else if (user_wr_in && (user_idx_in <= gcc_pkg::IDX_LAST)) begin
			user_tbl_r[user_idx_in] <= user_data_in;
		end
	end

	// ************************************************************
	// Curve builder
	// ************************************************************
	// Gamma source: preset table or the uploaded points
	assign gam_pt = (cfg_r[gcc_pkg::GAM_LSB +: 3] == gcc_pkg::GAM_USER) ?
		user_tbl_r[idx_r] : gcc_pkg::gam_entry(cfg_r[gcc_pkg::GAM_LSB +: 3], idx_r);

	// Contrast reshapes whichever gamma point is current
	gcc_scurve u_scurve (
		.val_in  (gam_pt),
		.con_in  (cfg_r[gcc_pkg::CON_LSB +: 3]),
		.val_out (con_pt)
	);

	// One breakpoint per cycle, nineteen cycles per build
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= ST_IDLE;
			idx_r   <= 5'h00;
			cfg_r   <= gcc_pkg::CFG_RST;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (start) begin
						cfg_r   <= cur_cfg;
						idx_r   <= 5'h00;
						state_r <= ST_BUILD;
					end
				end
				ST_BUILD: begin
					if (idx_r == gcc_pkg::IDX_LAST) begin
						state_r <= ST_IDLE;
					end else begin
						idx_r <= idx_r + 5'h01;
					end
				end
			endcase
		end
	end

	// Combined points land in the pending curve, not the live one
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pend_tbl_r <= gcc_pkg::GAM_TBL_ID;
		end else if (state_r == ST_BUILD) begin
			pend_tbl_r[{idx_r, 3'b000} +: 8] <= con_pt;
		end
	end

	// ************************************************************
	// Frame-aligned curve swap
	// ************************************************************
	// Swap only while idle so a half-built curve is never taken
	assign swap_now = px_in.valid && px_in.sof && swap_pend_r && (state_r == ST_IDLE);

	// Pending flag: set when a build ends, cleared when a build starts or
	// the curve goes live; the end of a build wins
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			swap_pend_r <= 1'b0;
		end else if ((state_r == ST_BUILD) && (idx_r == gcc_pkg::IDX_LAST)) begin
			swap_pend_r <= 1'b1;
		end else if (start || swap_now) begin
			swap_pend_r <= 1'b0;
		end
	end

	// Live curve
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			act_tbl_r <= gcc_pkg::GAM_TBL_ID;
		end else if (swap_now) begin
			act_tbl_r <= pend_tbl_r;
		end
	end

	// The first pixel of a frame already uses the new curve
	assign cur_tbl = swap_now ? pend_tbl_r : act_tbl_r;
	assign top_y   = cur_tbl[{gcc_pkg::IDX_LAST, 3'b000} +: 8];
	assign bot_y   = cur_tbl[7:0];

	// ************************************************************
	// Pixel path
	// ************************************************************
	// Three identical lookups share one curve
	gcc_interp u_int_r (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.x_in    (px_in.r),
		.tbl_in  (cur_tbl),
		.y_out   (y_r)
	);

	gcc_interp u_int_g (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.x_in    (px_in.g),
		.tbl_in  (cur_tbl),
		.y_out   (y_g)
	);

	gcc_interp u_int_b (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.x_in    (px_in.b),
		.tbl_in  (cur_tbl),
		.y_out   (y_b)
	);

	// Markers travel beside the data, one output per input
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			valid_r <= 1'b0;
			sof_r   <= 1'b0;
		end else begin
			valid_r <= px_in.valid;
			sof_r   <= px_in.valid && px_in.sof;
		end
	end

	// Output assembly
	always_comb begin
		px_out.valid = valid_r;
		px_out.sof   = sof_r;
		px_out.r     = y_r;
		px_out.g     = y_g;
		px_out.b     = y_b;
	end

	assign busy_out          = (state_r == ST_BUILD);
	assign curve_pending_out = swap_pend_r;

	// ************************************************************
	// Assertions
	// ************************************************************
	// Nineteen busy cycles, then idle with a curve waiting
	sequence s_build_run;
		busy_out [*8] ##1 busy_out [*8] ##1 busy_out [*3];
	endsequence

	sequence s_build_end;
		!busy_out && curve_pending_out;
	endsequence

	a_build_run_len: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		start |=> s_build_run ##1 s_build_end)
		else $error("curve build did not take nineteen cycles");

	a_identity_curve: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(start && cur_cfg == 8'h00 && !user_wr_in) |-> ##20 (pend_tbl_r == gcc_pkg::GAM_TBL_ID))
		else $error("identity presets did not give identity curve");

	a_mode_b_pick: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(start && mode_b_sel_in) |=> (cfg_r == $past(mode_b_cfg_in)))
		else $error("second mode preset byte not used");

	a_user_store: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(user_wr_in && user_idx_in <= gcc_pkg::IDX_LAST) |=>
			(user_tbl_r[$past(user_idx_in)] == $past(user_data_in)))
		else $error("uploaded point not stored");

	a_swap_frame_only: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		!$stable(act_tbl_r) |-> $past(swap_now))
		else $error("live curve changed away from frame start");

	a_no_swap_busy: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		busy_out |-> !curve_pending_out)
		else $error("curve offered while still building");

	a_out_per_in: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		##1 (px_out.valid == $past(px_in.valid)))
		else $error("output count differs from input count");

	a_rgb_same: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(px_in.valid && px_in.r == px_in.b) |=> (px_out.r == px_out.b))
		else $error("red and blue mapped differently");

	a_white_end: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(px_in.valid && px_in.g == gcc_pkg::BP_LAST) |=> (px_out.g == $past(top_y)))
		else $error("full scale input missed the top point");

	a_black_end: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(px_in.valid && px_in.r == 12'h000) |=> (px_out.r == $past(bot_y)))
		else $error("black input missed the first point");

	// A request in any cycle survives, even the start cycle
	a_rebuild_kept: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(rebuild_in || user_wr_in) |=> req_r)
		else $error("rebuild request lost");

	// A start with no fresh request leaves nothing owed
	a_req_consumed: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(start && !rebuild_in && !user_wr_in) |=> !req_r)
		else $error("build started twice for one request");

	// The waiting curve goes live whole and the flag drops
	a_swap_takes_curve: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		swap_now |=> (!curve_pending_out && act_tbl_r == $past(pend_tbl_r)))
		else $error("frame start did not take the waiting curve");

	// A frame marker never leaves without a pixel
	a_sof_with_valid: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		px_out.sof |-> px_out.valid)
		else $error("frame start without a pixel");

	// An input on the second breakpoint returns its stored point exactly
	a_breakpoint_hit: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(px_in.valid && px_in.g == 12'h040) |=> (px_out.g == $past(cur_tbl[15:8])))
		else $error("breakpoint input missed its point");

endmodule

// File: gcc_px_src.sv
// ************************************************************
// Upstream colour pipeline model
// ************************************************************
module gcc_px_src (
	input  wire logic            clk_in,
	output gcc_pkg::gcc_pix_in_t px_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// Quiet stream from time zero
	initial px_out = '0;

	// One pixel or idle cycle, launched at the falling edge
	task automatic drive(input logic v, input logic s, input logic [35:0] rgb);
		@(negedge clk_in);
		// Idle data wanders, so a stale value never passes for a pixel
		px_out <= {v, v & s, v ? rgb : 36'($urandom)};
	endtask
endmodule

// File: gcc_tone_curve_tb.sv
// ************************************************************
// Tone curve bench
// ************************************************************
module gcc_tone_curve_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic                  clk_in        = 1'b0;
	logic                  rstn_in       = 1'b0;
	gcc_pkg::gcc_pix_in_t  px_in;
	gcc_pkg::gcc_pix_out_t px_out;
	logic                  mode_b_sel_in = 1'b0;
	logic [7:0]            mode_a_cfg_in = 8'h00;
	logic [7:0]            mode_b_cfg_in = 8'h00;
	logic                  user_wr_in    = 1'b0;
	logic [4:0]            user_idx_in   = 5'h00;
	logic [7:0]            user_data_in  = 8'h00;
	logic                  rebuild_in    = 1'b0;
	logic                  busy_out;
	logic                  curve_pending_out;
	int                    errors          = 0;
	int                    samples_checked = 0;
	logic [7:0]            act_tbl [19];   // Curve live in the design now
	logic [7:0]            new_tbl [19];   // Curve the next build yields
	logic [7:0]            usr_tbl [19];   // Uploaded gamma points
	gcc_pkg::gcc_pix_out_t exp_q [$];      // Expected results, oldest first
	int                    slp [6] = '{8, gcc_pkg::SLOPE_125, gcc_pkg::SLOPE_150,
		gcc_pkg::SLOPE_175, gcc_pkg::SLOPE_NR, 8};

	// 10 MHz clock
	always #50 clk_in = ~clk_in;

	gcc_px_src src_u (
		.clk_in (clk_in),
		.px_out (px_in)
	);

	gcc_tone_curve dut_u (
		.clk_in            (clk_in),
		.rstn_in           (rstn_in),
		.px_in             (px_in),
		.px_out            (px_out),
		.mode_b_sel_in     (mode_b_sel_in),
		.mode_a_cfg_in     (mode_a_cfg_in),
		.mode_b_cfg_in     (mode_b_cfg_in),
		.user_wr_in        (user_wr_in),
		.user_idx_in       (user_idx_in),
		.user_data_in      (user_data_in),
		.rebuild_in        (rebuild_in),
		.busy_out          (busy_out),
		.curve_pending_out (curve_pending_out)
	);

	// ************************************************************
	// Reference model
	// ************************************************************
	function automatic int bpx(input int i);
		return (i == 0) ? 0 : (i == 1) ? 64 : (i == 2) ? 128 : (i == 18) ? 4095 : (i - 2) * 256;
	endfunction

	// Interpolation; the top point is returned exactly, not reached by the slope
	function automatic logic [7:0] map(input logic [11:0] x);
		int j, w, d;
		if (x == 12'hfff) return act_tbl[18];
		j = (x < 64) ? 0 : (x < 128) ? 1 : (x < 256) ? 2 : int'(x) / 256 + 2;
		w = (j < 2) ? 64 : (j == 2) ? 128 : 256;
		d = (int'(act_tbl[j + 1]) - int'(act_tbl[j])) * (int'(x) - bpx(j));
		// Falling segments round down, not toward zero
		d = int'(act_tbl[j]) + ((d < 0) ? -((w - 1 - d) / w) : d / w);
		return 8'((d > 255) ? 255 : d);
	endfunction

	// S-curve on one point, flat quadratic ends joined to a straight middle
	function automatic int scv(input int v, input int s);
		int x1, k, y;
		if (s == 8) return v;
		x1 = 255 * (s - 8) / s;
		k = 4096 * s / x1;
		if (v <= x1) y = (k * v * v) >>> 16;
		else if (v >= 255 - x1) y = 255 - ((k * (255 - v) * (255 - v)) >>> 16);
		else y = 128 + ((s * (v - 128)) >>> 3);
		return (y < 0) ? 0 : (y > 255) ? 255 : y;
	endfunction

	// Combined curve for a gamma and a contrast code
	task automatic build(input int g, input int c);
		for (int i = 0; i < 19; i++) begin
			logic [7:0] b;
			b = (g == 3) ? usr_tbl[i] : (g == 1) ? gcc_pkg::GAM_TBL_056[i * 8 +: 8] :
				(g == 2) ? gcc_pkg::GAM_TBL_045[i * 8 +: 8] : gcc_pkg::GAM_TBL_ID[i * 8 +: 8];
			new_tbl[i] = 8'(scv(int'(b), slp[c]));
		end
	endtask

	// ************************************************************
	// Checking
	// ************************************************************
	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask

	// Every output pixel takes the oldest note
	always @(negedge clk_in) begin
		if (rstn_in && px_out.valid === 1'b1) begin
			if (exp_q.size() == 0) check(1'b0, "unexpected pixel");
			else check(px_out === exp_q.pop_front(), "pixel mismatch");
		end
	end

	task automatic report_and_stop();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ************************************************************
	// Stimulus
	// ************************************************************
	// Note the expectation, then send; a frame start makes the new curve live
	task automatic pix(input logic s, input logic [11:0] r, g, b);
		if (s) act_tbl = new_tbl;
		exp_q.push_back({1'b1, s, map(r), map(g), map(b)});
		src_u.drive(1'b1, s, {r, g, b});
	endtask

	// Builder idle with a waiting curve for three cycles in a row
	task automatic wait_curve();
		int n = 0;
		for (int t = 0; t < 400 && n < 3; t++) begin
			@(negedge clk_in);
			n = (curve_pending_out === 1'b1 && busy_out === 1'b0) ? n + 1 : 0;
		end
		check(n == 3, "curve not ready");
		if (n != 3) report_and_stop();
	endtask

	// Old curve holds mid-frame, swaps at the frame start, then sweeps breakpoints
	task automatic frame(input logic sel);
		if (sel) mode_a_cfg_in = 8'($urandom);
		else mode_b_cfg_in = 8'($urandom);
		pix(1'b0, 12'h000, 12'h040, 12'hfff);
		pix(1'b1, 12'h000, 12'h080, 12'hfff);
		pix(1'b0, 12'h7ff, 12'h13f, 12'h03f);
		check(curve_pending_out === 1'b0, "curve still waiting");
		check(busy_out === 1'b0, "unselected byte started a build");
		for (int i = 0; i < 19; i++) begin
			if ($urandom % 4 == 0) src_u.drive(1'b0, 1'b0, 36'h0);
			pix(1'b0, 12'(bpx(i)), 12'(bpx(i) - 1), 12'($urandom));
		end
		// Back to idle, so the last pixel does not repeat between frames
		src_u.drive(1'b0, 1'b0, 36'h0);
	endtask

	initial begin
		logic [7:0] cfg;
		logic [7:0] uv;
		void'($urandom(32'hce8c));
		build(0, 0);
		act_tbl = new_tbl;
		repeat (4) @(posedge clk_in);
		check(busy_out === 1'b0 && curve_pending_out === 1'b0 && px_out === '0, "reset");
		@(negedge clk_in);
		rstn_in = 1'b1;
		wait_curve();
		frame(1'b0);
		// Back-to-back upload of a rising curve; index 19 must be ignored
		uv = 8'h00;
		for (int i = 0; i < 20; i++) begin
			@(negedge clk_in);
			user_wr_in = 1'b1;
			user_idx_in = 5'(i);
			user_data_in = (i == 19) ? 8'h00 : uv;
			if (i < 19) usr_tbl[i] = uv;
			uv = (uv > 8'hdc) ? 8'hff : uv + 8'($urandom % 20);
		end
		@(negedge clk_in);
		user_wr_in = 1'b0;
		// Every gamma and contrast code, either mode; the last pass of each
		// loop picks a random spare code, which acts as identity or as none
		for (int g = 0; g < 5; g++) begin
			for (int c = 0; c < 6; c++) begin
				cfg = {1'($urandom), (c == 5) ? 3'(5 + $urandom % 3) : 3'(c),
					1'($urandom), (g == 4) ? 3'(4 + $urandom % 4) : 3'(g)};
				mode_b_sel_in = 1'($urandom);
				if (mode_b_sel_in) mode_b_cfg_in = cfg;
				else mode_a_cfg_in = cfg;
				rebuild_in = 1'b1;
				@(negedge clk_in);
				rebuild_in = 1'b0;
				build(g, c);
				wait_curve();
				frame(mode_b_sel_in);
			end
		end
		// Mid-run reset: uploaded points fall back to identity, and the
		// build owed out of reset reads them through the user gamma code
		mode_b_sel_in = 1'b0;
		mode_a_cfg_in = {5'h00, gcc_pkg::GAM_USER};
		repeat (2) @(negedge clk_in);
		rstn_in = 1'b0;
		@(negedge clk_in);
		check(busy_out === 1'b0 && curve_pending_out === 1'b0 && px_out === '0,
			"reset again");
		rstn_in = 1'b1;
		for (int i = 0; i < 19; i++) usr_tbl[i] = gcc_pkg::GAM_TBL_ID[i * 8 +: 8];
		build(3, 0);
		wait_curve();
		frame(1'b0);
		repeat (3) @(negedge clk_in);
		check(exp_q.size() == 0, "missing pixel");
		report_and_stop();
	end
endmodule
